// [core/prog_port_pkg.sv]
package prog_port_pkg;

	// ********************************************************************
	// Action select codes sampled on the action strobe.
	// ********************************************************************
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;

	// ********************************************************************
	// Command byte codes.
	// ********************************************************************
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE = 8'h11;
	localparam logic [7:0] CMD_RD_SIG = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE = 8'h03;

	// ********************************************************************
	// Byte select codes as {second, first}.
	// ********************************************************************
	localparam logic [1:0] SEL_LOW = 2'h0;
	localparam logic [1:0] WR_SEL_HIGH = 2'h1;
	localparam logic [1:0] WR_SEL_EXT = 2'h2;
	localparam logic [1:0] RD_SEL_LOCK = 2'h1;
	localparam logic [1:0] RD_SEL_EXT = 2'h2;
	localparam logic [1:0] RD_SEL_HIGH = 2'h3;

	// ********************************************************************
	// Entry pattern, reset and erased values, field positions.
	// ********************************************************************
	localparam logic [3:0] ENTRY_PATTERN = 4'h0;
	localparam logic [7:0] FUSE_LOW_RST = 8'h62;
	localparam logic [7:0] FUSE_HIGH_RST = 8'hdf;
	localparam logic [7:0] FUSE_EXT_RST = 8'hf9;
	localparam logic [7:0] LOCK_RST = 8'hff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam int KEEP_EE_BIT = 3;

	// ********************************************************************
	// Timing.
	// ********************************************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int ENTRY_HOLD_NS = 10000;
	localparam int ENTRY_HOLD_CYCLES = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ENTRY_CNT_W = 12;

	// ********************************************************************
	// Mode and operation states.
	// ********************************************************************
	typedef enum logic [1:0] {MD_OFF, MD_LATCH, MD_ON, MD_REJECT} mode_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ERASE_FLASH, ST_ERASE_EE, ST_ERASE_LOCK,
		ST_PROG_FLASH, ST_PROG_EE, ST_SETTLE
	} op_state_t;

endpackage

// [core/edge_pulse.sv]
`timescale 1ns/10ps
module edge_pulse #(
	parameter bit RISE = 1'b1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic level,
	output logic pulse
);

	logic prev_r;

	// Previous sample, reset to the idle level so no edge appears at release.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_r <= ~RISE;
		end else begin
			prev_r <= level;
		end
	end

	// One-cycle pulse on the chosen edge.
	assign pulse = RISE ? (level & ~prev_r) : (~level & prev_r);

endmodule // edge_pulse

// [core/parallel_hv_programming_port.sv]
`timescale 1ns/10ps
module parallel_hv_programming_port
	import prog_port_pkg::*;
#(
	parameter int FLASH_AW = 12,
	parameter int PAGE_AW = 5,
	parameter int EE_AW = 9,
	parameter int EE_PAGE_AW = 2,
	parameter int OP_SETTLE_CYCLES = 16,
	parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary value.
	parameter logic [7:0] SIG_BYTE1 = 8'h01, // Arbitrary value.
	parameter logic [7:0] SIG_BYTE2 = 8'h02, // Arbitrary value.
	parameter logic [7:0] CAL_BYTE = 8'h80 // Arbitrary value.
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic prog_hv,
	input wire logic action_strobe_pin,
	input wire logic action_select_0,
	input wire logic action_select_1,
	input wire logic byte_select_first,
	input wire logic byte_select_second,
	input wire logic page_load_strobe,
	input wire logic wr_n,
	input wire logic oe_n,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic ready_busy_out,
	output logic prog_mode
);

	localparam logic [FLASH_AW-1:0] FLASH_LAST = FLASH_AW'((1 << FLASH_AW) - 1);
	localparam logic [FLASH_AW-1:0] EE_LAST = FLASH_AW'((1 << EE_AW) - 1);
	localparam logic [FLASH_AW-1:0] PAGE_LAST = FLASH_AW'((1 << PAGE_AW) - 1);
	localparam logic [FLASH_AW-1:0] EPAGE_LAST = FLASH_AW'((1 << EE_PAGE_AW) - 1);
	localparam logic [FLASH_AW-1:0] SETTLE_LAST = FLASH_AW'(OP_SETTLE_CYCLES - 1);
	localparam logic [FLASH_AW-1:0] WALK_ZERO = '0;
	localparam logic [ENTRY_CNT_W-1:0] ENTRY_LAST = ENTRY_CNT_W'(ENTRY_HOLD_CYCLES - 1);

	// ********************************************************************
	// Strobe edge detection.
	// ********************************************************************
	logic act_pulse;
	logic pl_pulse;
	logic wr_pulse;

	edge_pulse #(.RISE(1'b1)) u_act (
		.clk(clk), .arst_n(arst_n), .level(action_strobe_pin), .pulse(act_pulse));
	edge_pulse #(.RISE(1'b1)) u_pl (
		.clk(clk), .arst_n(arst_n), .level(page_load_strobe), .pulse(pl_pulse));
	edge_pulse #(.RISE(1'b0)) u_wr (
		.clk(clk), .arst_n(arst_n), .level(wr_n), .pulse(wr_pulse));

	// ********************************************************************
	// Programming mode entry and exit.
	// ********************************************************************
	mode_t mode_r;
	mode_t mode_nxt;
	logic [ENTRY_CNT_W-1:0] entry_cnt_r;
	logic [3:0] entry_pins;
	logic prog_on;

	assign entry_pins = {page_load_strobe, action_select_1, action_select_0, byte_select_first};
	assign prog_on = (mode_r == MD_ON);

	// Pattern is sampled once, on the last cycle of the latch window, and judged there.
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			MD_OFF: begin
				if (prog_hv) mode_nxt = MD_LATCH;
			end
			MD_LATCH: begin
				if (entry_cnt_r == ENTRY_LAST) begin
					mode_nxt = (entry_pins == ENTRY_PATTERN) ? MD_ON : MD_REJECT;
				end
			end
			MD_ON: ;
			MD_REJECT: ;
		endcase
		if (!prog_hv) mode_nxt = MD_OFF;
	end

	// Mode register and latch window counter.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= MD_OFF;
			entry_cnt_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			entry_cnt_r <= (mode_r == MD_LATCH) ? entry_cnt_r + 1'b1 : '0;
		end
	end

	// ********************************************************************
	// Command, address and data loading.
	// ********************************************************************
	logic [1:0] act_sel;
	logic [1:0] bsel;
	logic ld_cmd;
	logic ld_addr;
	logic ld_data;
	logic [7:0] cmd_r;
	logic [7:0] addr_lo_r;
	logic [7:0] addr_hi_r;
	logic [7:0] data_lo_r;
	logic [7:0] data_hi_r;
	logic [15:0] addr;

	assign act_sel = {action_select_1, action_select_0};
	assign bsel = {byte_select_second, byte_select_first};
	assign ld_cmd = prog_on & act_pulse & (act_sel == ACT_CMD);
	assign ld_addr = prog_on & act_pulse & (act_sel == ACT_ADDR);
	assign ld_data = prog_on & act_pulse & (act_sel == ACT_DATA);
	assign addr = {addr_hi_r, addr_lo_r};

	// Loads happen only on the strobe edge; values persist otherwise.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_r <= CMD_NOP;
			addr_lo_r <= '0;
			addr_hi_r <= '0;
			data_lo_r <= ERASED_BYTE;
			data_hi_r <= ERASED_BYTE;
		end else begin
			if (ld_cmd) cmd_r <= data_in;
			if (ld_addr && !byte_select_first) addr_lo_r <= data_in;
			if (ld_addr && byte_select_first) addr_hi_r <= data_in;
			if (ld_data && !byte_select_first) data_lo_r <= data_in;
			if (ld_data && byte_select_first) data_hi_r <= data_in;
		end
	end

	// ********************************************************************
	// Operation sequencer.
	// ********************************************************************
	op_state_t st_r;
	op_state_t st_nxt;
	op_state_t start_st;
	logic [FLASH_AW-1:0] walk_r;
	logic [FLASH_AW-1:0] walk_nxt;
	logic [FLASH_AW-1:0] walk_limit;
	logic walk_last;
	logic wr_go;
	logic keep_ee;
	logic [7:0] fuse_low_r;
	logic [7:0] fuse_high_r;
	logic [7:0] fuse_ext_r;
	logic [7:0] lock_r;

	assign wr_go = prog_on & wr_pulse & (st_r == ST_IDLE);
	assign keep_ee = ~fuse_high_r[KEEP_EE_BIT];
	assign start_st = (cmd_r == CMD_ERASE) ? ST_ERASE_FLASH :
		(cmd_r == CMD_WR_FLASH) ? ST_PROG_FLASH :
		(cmd_r == CMD_WR_EE) ? ST_PROG_EE :
		(cmd_r == CMD_WR_FUSE || cmd_r == CMD_WR_LOCK) ? ST_SETTLE : ST_IDLE;
	assign walk_limit = (st_r == ST_ERASE_FLASH) ? FLASH_LAST :
		(st_r == ST_ERASE_EE) ? EE_LAST :
		(st_r == ST_PROG_FLASH) ? PAGE_LAST :
		(st_r == ST_PROG_EE) ? EPAGE_LAST :
		(st_r == ST_SETTLE) ? SETTLE_LAST : WALK_ZERO;
	assign walk_last = (walk_r == walk_limit);

	// Erase walks flash, then EEPROM unless keep_ee skips it, and only then restores the lock bits.
	always_comb begin
		st_nxt = st_r;
		walk_nxt = walk_last ? WALK_ZERO : walk_r + 1'b1;
		unique case (st_r)
			ST_IDLE: begin
				walk_nxt = WALK_ZERO;
				if (wr_go) st_nxt = start_st;
			end
			ST_ERASE_FLASH: begin
				if (walk_last) st_nxt = keep_ee ? ST_ERASE_LOCK : ST_ERASE_EE;
			end
			ST_ERASE_EE: begin
				if (walk_last) st_nxt = ST_ERASE_LOCK;
			end
			ST_ERASE_LOCK: st_nxt = ST_SETTLE;
			ST_PROG_FLASH: begin
				if (walk_last) st_nxt = ST_SETTLE;
			end
			ST_PROG_EE: begin
				if (walk_last) st_nxt = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (walk_last) st_nxt = ST_IDLE;
			end
			// The unused state code falls back to idle.
			default: st_nxt = ST_IDLE;
		endcase
		if (!prog_on) begin
			st_nxt = ST_IDLE;
			walk_nxt = WALK_ZERO;
		end
	end

	// Sequencer state and walk counter.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= ST_IDLE;
			walk_r <= '0;
		end else begin
			st_r <= st_nxt;
			walk_r <= walk_nxt;
		end
	end

	// Fuses only change by a fuse write; lock bits only program to zero or erase.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fuse_low_r <= FUSE_LOW_RST;
			fuse_high_r <= FUSE_HIGH_RST;
			fuse_ext_r <= FUSE_EXT_RST;
			lock_r <= LOCK_RST;
		end else begin
			if (wr_go && cmd_r == CMD_WR_FUSE && bsel == SEL_LOW) fuse_low_r <= data_lo_r;
			if (wr_go && cmd_r == CMD_WR_FUSE && bsel == WR_SEL_HIGH) fuse_high_r <= data_lo_r;
			if (wr_go && cmd_r == CMD_WR_FUSE && bsel == WR_SEL_EXT) fuse_ext_r <= data_lo_r;
			if (st_r == ST_ERASE_LOCK) begin
				lock_r <= LOCK_RST;
			end else if (wr_go && cmd_r == CMD_WR_LOCK) begin
				lock_r <= lock_r & data_lo_r;
			end
		end
	end

	// ********************************************************************
	// Page buffers and memory arrays.
	// ********************************************************************
	logic [15:0] flash_mem [0:(1 << FLASH_AW)-1];
	logic [7:0] ee_mem [0:(1 << EE_AW)-1];
	logic [15:0] page_buf [0:(1 << PAGE_AW)-1];
	logic [7:0] ee_buf [0:(1 << EE_PAGE_AW)-1];
	logic [(1 << PAGE_AW)-1:0] pvalid_r;
	logic [(1 << EE_PAGE_AW)-1:0] evalid_r;
	// Single set bits at the mark widths, so a shifted mark never drops bits.
	localparam logic [(1 << PAGE_AW)-1:0] PMARK_ONE = {{((1 << PAGE_AW)-1){1'b0}}, 1'b1};
	localparam logic [(1 << EE_PAGE_AW)-1:0] EMARK_ONE = {{((1 << EE_PAGE_AW)-1){1'b0}}, 1'b1};
	logic pbuf_we;
	logic ebuf_we;
	logic buf_clr;
	logic [PAGE_AW-1:0] pidx;
	logic [EE_PAGE_AW-1:0] eidx;
	logic flash_we;
	logic ee_we;
	logic [FLASH_AW-1:0] flash_wa;
	logic [EE_AW-1:0] ee_wa;
	logic [15:0] flash_wd;
	logic [7:0] ee_wd;

	assign pbuf_we = prog_on & pl_pulse & (cmd_r == CMD_WR_FLASH);
	assign ebuf_we = prog_on & pl_pulse & (cmd_r == CMD_WR_EE);
	assign buf_clr = (ld_cmd && data_in == CMD_NOP) ||
		((st_r == ST_PROG_FLASH || st_r == ST_PROG_EE) && walk_last);
	assign pidx = addr[PAGE_AW-1:0];
	assign eidx = addr[EE_PAGE_AW-1:0];
	assign flash_we = (st_r == ST_ERASE_FLASH) ||
		(st_r == ST_PROG_FLASH && pvalid_r[walk_r[PAGE_AW-1:0]]);
	assign flash_wa = (st_r == ST_ERASE_FLASH) ? walk_r :
		{addr[FLASH_AW-1:PAGE_AW], walk_r[PAGE_AW-1:0]};
	assign flash_wd = (st_r == ST_ERASE_FLASH) ? ERASED_WORD : page_buf[walk_r[PAGE_AW-1:0]];
	assign ee_we = (st_r == ST_ERASE_EE) ||
		(st_r == ST_PROG_EE && evalid_r[walk_r[EE_PAGE_AW-1:0]]);
	assign ee_wa = (st_r == ST_ERASE_EE) ? walk_r[EE_AW-1:0] :
		{addr[EE_AW-1:EE_PAGE_AW], walk_r[EE_PAGE_AW-1:0]};
	assign ee_wd = (st_r == ST_ERASE_EE) ? ERASED_BYTE : ee_buf[walk_r[EE_PAGE_AW-1:0]];

	// Valid marks; a page load in the clearing cycle still counts.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pvalid_r <= '0;
			evalid_r <= '0;
		end else begin
			pvalid_r <= (buf_clr ? '0 : pvalid_r) | (pbuf_we ? (PMARK_ONE << pidx) : '0);
			evalid_r <= (buf_clr ? '0 : evalid_r) | (ebuf_we ? (EMARK_ONE << eidx) : '0);
		end
	end

	// Array storage holds no reset.
	always_ff @(posedge clk) begin
		if (flash_we) flash_mem[flash_wa] <= flash_wd;
		if (ee_we) ee_mem[ee_wa] <= ee_wd;
		if (pbuf_we) page_buf[pidx] <= {data_hi_r, data_lo_r};
		if (ebuf_we) ee_buf[eidx] <= data_lo_r;
	end

	// ********************************************************************
	// Read path and outputs.
	// ********************************************************************
	logic [7:0] sig_byte;
	logic [7:0] rd_sig;
	logic [7:0] rd_fuse;
	logic [15:0] flash_word;
	logic [7:0] rd_byte;
	logic [7:0] data_out_r;

	assign sig_byte = (addr_lo_r[1:0] == 2'h0) ? SIG_BYTE0 :
		(addr_lo_r[1:0] == 2'h1) ? SIG_BYTE1 :
		(addr_lo_r[1:0] == 2'h2) ? SIG_BYTE2 : ERASED_BYTE;
	assign rd_sig = byte_select_first ? CAL_BYTE : sig_byte;
	assign rd_fuse = (bsel == SEL_LOW) ? fuse_low_r :
		(bsel == RD_SEL_HIGH) ? fuse_high_r :
		(bsel == RD_SEL_EXT) ? fuse_ext_r : lock_r;
	assign flash_word = flash_mem[addr[FLASH_AW-1:0]];
	assign rd_byte = (cmd_r == CMD_RD_SIG) ? rd_sig :
		(cmd_r == CMD_RD_FUSE) ? rd_fuse :
		(cmd_r == CMD_RD_FLASH) ? (byte_select_first ? flash_word[15:8] : flash_word[7:0]) :
		(cmd_r == CMD_RD_EE) ? ee_mem[addr[EE_AW-1:0]] : ERASED_BYTE;

	// Read data is registered while output enable is low.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out_r <= '0;
		end else if (prog_on && !oe_n) begin
			data_out_r <= rd_byte;
		end
	end

	assign data_out = data_out_r;
	assign data_oe = prog_on & ~oe_n;
	assign ready_busy_out = prog_on & (st_r == ST_IDLE);
	assign prog_mode = prog_on;

	// ********************************************************************
	// Checks.
	// ********************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_erase_loaded;
		cmd_r == CMD_ERASE && st_r == ST_IDLE && prog_on;
	endsequence
	sequence s_wr_edge;
		wr_pulse && prog_hv;
	endsequence
	property p_erase_start;
		(s_erase_loaded and s_wr_edge) |=> (st_r == ST_ERASE_FLASH) && !ready_busy_out;
	endproperty

	cmd_load_a: assert property (ld_cmd |=> cmd_r == $past(data_in))
		else $error("command byte not loaded");
	addr_high_a: assert property (ld_addr && byte_select_first |=>
		addr_hi_r == $past(data_in) && $stable(addr_lo_r))
		else $error("address high byte wrong");
	fuse_ext_a: assert property (wr_go && cmd_r == CMD_WR_FUSE && bsel == WR_SEL_EXT |=>
		fuse_ext_r == $past(data_lo_r) && $stable(fuse_low_r))
		else $error("extended fuse write wrong");
	lock_write_a: assert property (wr_go && cmd_r == CMD_WR_LOCK |=>
		lock_r == ($past(lock_r) & $past(data_lo_r)) && !ready_busy_out)
		else $error("lock write wrong");
	lock_read_a: assert property (prog_on && !oe_n && cmd_r == CMD_RD_FUSE &&
		bsel == RD_SEL_LOCK ##1 prog_on |-> data_out == $past(lock_r))
		else $error("lock read wrong");
	erase_start_a: assert property (p_erase_start)
		else $error("erase did not start busy");
	bus_drive_a: assert property (data_oe |-> !oe_n && prog_mode)
		else $error("bus driven without output enable");
	lock_order_a: assert property (st_r == ST_ERASE_LOCK |->
		$past(st_r) == ST_ERASE_EE || ($past(st_r) == ST_ERASE_FLASH && keep_ee))
		else $error("lock cleared before memory erase");
	fuse_kept_a: assert property (st_r != ST_IDLE && st_r != ST_SETTLE |=>
		$stable(fuse_low_r) && $stable(fuse_high_r) && $stable(fuse_ext_r))
		else $error("fuse changed during erase");
	keep_ee_a: assert property (st_r == ST_ERASE_FLASH && walk_last && keep_ee && prog_on &&
		prog_hv |=> st_r == ST_ERASE_LOCK)
		else $error("EEPROM erased despite keep fuse");
	page_load_a: assert property (pbuf_we |=> pvalid_r[$past(pidx)])
		else $error("page load not marked");
	nop_clear_a: assert property (ld_cmd && data_in == CMD_NOP && !pl_pulse |=>
		pvalid_r == '0 && evalid_r == '0)
		else $error("no-op did not clear page state");
	page_addr_a: assert property (st_r == ST_PROG_FLASH && flash_we |->
		flash_wa[FLASH_AW-1:PAGE_AW] == addr[FLASH_AW-1:PAGE_AW])
		else $error("page write outside page");
	hold_a: assert property (!act_pulse |=> $stable(cmd_r) && $stable(addr) &&
		$stable(data_lo_r) && $stable(data_hi_r))
		else $error("load without strobe");
	entry_a: assert property (mode_r == MD_LATCH && entry_cnt_r == ENTRY_LAST && prog_hv &&
		entry_pins == ENTRY_PATTERN |=> prog_mode ##0 ready_busy_out)
		else $error("entry pattern not accepted");
	exit_a: assert property (prog_on && !prog_hv |=> !prog_mode && !ready_busy_out)
		else $error("mode kept after reset dropped");

endmodule // parallel_hv_programming_port

// [testbench/hv_programmer_model.sv]
`timescale 1ns/10ps
module hv_programmer_model (
	input wire logic clk,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic ready_busy_out,
	output logic prog_hv,
	output logic action_strobe_pin,
	output logic action_select_0,
	output logic action_select_1,
	output logic byte_select_first,
	output logic byte_select_second,
	output logic page_load_strobe,
	output logic wr_n,
	output logic oe_n,
	output logic [7:0] data_in
);
	// ****************************************************************
	// Programmer side of the pins; action and page load strobes are held 250 ns, wr_n 255 ns.
	// ****************************************************************
	localparam int STROBE_CYC = 50;
	logic [7:0] drv_r = 8'h00;
	logic drv_en = 1'b0;
	// A released bus shows the inverse of the last value, never a stale copy.
	assign data_in = data_oe ? data_out : (drv_en ? drv_r : ~drv_r);
	initial begin
		{prog_hv, action_strobe_pin, action_select_0, action_select_1} = 4'h0;
		{byte_select_first, byte_select_second, page_load_strobe} = 3'h0;
		{wr_n, oe_n} = 2'h3;
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic enter(input logic [3:0] pat, input int hold);
		wait_cyc(1);
		{page_load_strobe, action_select_1, action_select_0, byte_select_first} = pat;
		prog_hv = 1'b1;
		wait_cyc(hold);
		{page_load_strobe, action_select_1, action_select_0, byte_select_first} = 4'h0;
	endtask
	task automatic leave();
		wait_cyc(1);
		prog_hv = 1'b0;
		wait_cyc(2);
	endtask
	task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] val);
		wait_cyc(1);
		{action_select_1, action_select_0} = act;
		{byte_select_second, byte_select_first} = bs;
		drv_r = val;
		drv_en = 1'b1;
		wait_cyc(2);
		action_strobe_pin = 1'b1;
		wait_cyc(STROBE_CYC);
		action_strobe_pin = 1'b0;
		wait_cyc(2);
		drv_en = 1'b0;
	endtask
	task automatic page_load();
		wait_cyc(1);
		page_load_strobe = 1'b1;
		wait_cyc(STROBE_CYC);
		page_load_strobe = 1'b0;
		wait_cyc(2);
	endtask
	task automatic write_op(input logic [1:0] bs, output logic busy0, output logic back);
		int n;
		wait_cyc(1);
		{byte_select_second, byte_select_first} = bs;
		wait_cyc(1);
		wr_n = 1'b0;
		wait_cyc(1);
		busy0 = ready_busy_out;
		wait_cyc(STROBE_CYC);
		wr_n = 1'b1;
		n = 0;
		while (ready_busy_out !== 1'b1 && n < 20000) begin
			wait_cyc(1);
			n++;
		end
		back = ready_busy_out;
	endtask
	task automatic read_byte(input logic [1:0] bs, output logic [7:0] val, output logic oe);
		wait_cyc(1);
		{byte_select_second, byte_select_first} = bs;
		oe_n = 1'b0;
		wait_cyc(3);
		val = data_in;
		oe = data_oe;
		oe_n = 1'b1;
		wait_cyc(2);
	endtask
endmodule // hv_programmer_model

// [testbench/tb_parallel_hv_programming_port.sv]
`timescale 1ns/10ps
module tb_parallel_hv_programming_port;
	import prog_port_pkg::*;
	// ****************************************************************
	// Clock, reset, pins and counters.
	// ****************************************************************
	localparam logic [7:0] SIG [4] = '{8'h3c, 8'h4d, 8'h6e, 8'h9b}; // Arbitrary values.
	logic clk, arst_n, hv, as_p, as0, as1, bs1, bs2, pl, wr_n, oe_n, oe, rb, pm;
	logic [7:0] din, dout, rd;
	logic busy0, back;
	int num_errors = 0;
	int compares = 0;
	parallel_hv_programming_port #(.FLASH_AW(6), .EE_AW(4), .SIG_BYTE0(SIG[0]),
		.SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]), .CAL_BYTE(SIG[3])) u_parallel_hv_programming_port (
		.clk(clk), .arst_n(arst_n), .prog_hv(hv), .action_strobe_pin(as_p),
		.action_select_0(as0), .action_select_1(as1), .byte_select_first(bs1),
		.byte_select_second(bs2), .page_load_strobe(pl), .wr_n(wr_n), .oe_n(oe_n),
		.data_in(din), .data_out(dout), .data_oe(oe), .ready_busy_out(rb), .prog_mode(pm));
	hv_programmer_model u_hv_programmer_model (.clk(clk), .data_out(dout), .data_oe(oe),
		.ready_busy_out(rb), .prog_hv(hv), .action_strobe_pin(as_p), .action_select_0(as0),
		.action_select_1(as1), .byte_select_first(bs1), .byte_select_second(bs2),
		.page_load_strobe(pl), .wr_n(wr_n), .oe_n(oe_n), .data_in(din));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ****************************************************************
	// Shared steps: command load, read with compare, write with busy.
	// ****************************************************************
	task automatic cmd(input logic [7:0] c);
		u_hv_programmer_model.load(ACT_CMD, SEL_LOW, c);
	endtask
	task automatic ld(input logic [1:0] act, input logic [7:0] v);
		u_hv_programmer_model.load(act, SEL_LOW, v);
	endtask
	task automatic rd_chk(input logic [1:0] bs, input logic [7:0] exp);
		u_hv_programmer_model.read_byte(bs, rd, busy0);
		check(rd, exp);
		check({7'h0, busy0}, 8'h01);
		check({7'h0, oe}, 8'h00);
	endtask
	task automatic op_chk(input logic [1:0] bs);
		u_hv_programmer_model.write_op(bs, busy0, back);
		check({7'h0, busy0}, 8'h00);
		check({7'h0, back}, 8'h01);
	endtask
	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic test_entry();
		check({6'h0, pm, rb}, 8'h00);
		u_hv_programmer_model.enter(4'h2, 2100);
		check({7'h0, pm}, 8'h00);
		u_hv_programmer_model.leave();
		u_hv_programmer_model.enter(ENTRY_PATTERN, 2100);
		check({6'h0, pm, rb}, 8'h03);
		u_hv_programmer_model.wait_cyc(60000);
	endtask
	task automatic test_fuses();
		cmd(CMD_RD_FUSE);
		rd_chk(SEL_LOW, FUSE_LOW_RST);
		rd_chk(RD_SEL_HIGH, FUSE_HIGH_RST);
		rd_chk(RD_SEL_LOCK, LOCK_RST);
		cmd(CMD_WR_FUSE);
		ld(ACT_DATA, 8'hf1);
		op_chk(WR_SEL_EXT);
		cmd(CMD_RD_FUSE);
		rd_chk(RD_SEL_EXT, 8'hf1);
		rd_chk(SEL_LOW, FUSE_LOW_RST);
	endtask
	task automatic test_flash();
		logic [15:0] w [3];
		w = '{16'h1234, 16'h5678, ERASED_WORD};
		cmd(CMD_ERASE);
		op_chk(SEL_LOW);
		cmd(CMD_WR_FLASH);
		for (int i = 0; i < 2; i++) begin
			ld(ACT_ADDR, 8'(3 + i));
			ld(ACT_DATA, w[i][7:0]);
			u_hv_programmer_model.load(ACT_DATA, WR_SEL_HIGH, w[i][15:8]);
			u_hv_programmer_model.page_load();
		end
		u_hv_programmer_model.load(ACT_ADDR, WR_SEL_HIGH, 8'h00);
		op_chk(SEL_LOW);
		cmd(CMD_NOP);
		cmd(CMD_RD_FLASH);
		ld(ACT_IDLE, CMD_WR_EE);
		for (int i = 0; i < 3; i++) begin
			ld(ACT_ADDR, 8'(3 + i));
			rd_chk(SEL_LOW, w[i][7:0]);
			rd_chk(WR_SEL_HIGH, w[i][15:8]);
		end
	endtask
	task automatic test_eeprom();
		cmd(CMD_RD_EE);
		ld(ACT_ADDR, 8'h02);
		rd_chk(SEL_LOW, ERASED_BYTE);
		cmd(CMD_WR_EE);
		ld(ACT_DATA, 8'ha5);
		u_hv_programmer_model.page_load();
		op_chk(SEL_LOW);
		cmd(CMD_RD_EE);
		rd_chk(SEL_LOW, 8'ha5);
	endtask
	task automatic test_keep_erase();
		cmd(CMD_WR_LOCK);
		ld(ACT_DATA, 8'hfc);
		op_chk(SEL_LOW);
		cmd(CMD_WR_FUSE);
		ld(ACT_DATA, FUSE_HIGH_RST & 8'hf7);
		op_chk(WR_SEL_HIGH);
		cmd(CMD_RD_FUSE);
		rd_chk(RD_SEL_LOCK, 8'hfc);
		cmd(CMD_ERASE);
		op_chk(SEL_LOW);
		cmd(CMD_RD_FUSE);
		rd_chk(RD_SEL_LOCK, LOCK_RST);
		rd_chk(RD_SEL_HIGH, FUSE_HIGH_RST & 8'hf7);
		cmd(CMD_RD_EE);
		rd_chk(SEL_LOW, 8'ha5);
		cmd(CMD_RD_FLASH);
		ld(ACT_ADDR, 8'h03);
		rd_chk(SEL_LOW, ERASED_BYTE);
	endtask
	task automatic test_sig();
		cmd(CMD_RD_SIG);
		for (int i = 0; i < 3; i++) begin
			ld(ACT_ADDR, 8'(i));
			rd_chk(SEL_LOW, SIG[i]);
		end
		rd_chk(WR_SEL_HIGH, SIG[3]);
		u_hv_programmer_model.leave();
		check({6'h0, pm, rb}, 8'h00);
	endtask
	// Main sequence and watchdog.
	initial begin
		arst_n = 1'b0;
		repeat (5) @(posedge clk);
		#1 arst_n = 1'b1;
		test_entry();
		test_fuses();
		test_flash();
		test_eeprom();
		test_keep_erase();
		test_sig();
		complete_run();
	end
	// The scenarios take about 70000 cycles, most of it the wait after entry.
	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		complete_run();
	end
endmodule // tb_parallel_hv_programming_port
